// [logic/stl_target.sv]
// I2C target front end of the secure module with its post-reset readiness timing.
// Core logic runs on ref_clk_in; bus-facing logic runs on the free-running link_clk_in.
// SCL and SDA are open-drain: the board provides the pull-ups and resolves the wire.
`timescale 1ns/1ps

module stl_target
  import stl_pkg::*;
#(
  parameter int         COMM_CYC      = COMM_READY_CYC,
  parameter int         DEFINED_CYC   = REG_DEFINED_CYC,
  parameter int         SELFTEST_CYC  = SELFTEST_READY_CYC,
  parameter int         TIMEOUT_CYC   = READY_TIMEOUT_CYC,
  parameter bit         SELFTEST_OPT  = 1'b0,
  parameter logic [1:0] LOCALITY_OPT  = LOC_ONLY_0,
  parameter bit         HIGH_SPEED    = 1'b0,
  parameter logic [3:0] GUARD_NEEDED  = 4'hf,
  parameter bit         GUARD_SR_NEED = 1'b1
) (
  input  wire logic                 ref_clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 link_clk_in,
  input  wire logic                 scl_in,
  output logic                      scl_out,
  output logic                      scl_oe_out,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_out,
  input  wire logic [6:0]           dev_addr_in,
  input  wire logic                 addr_load_in,
  output logic [7:0]                rx_data_out,
  output logic                      rx_first_out,
  output logic                      rx_valid_out,
  input  wire logic [7:0]           tx_data_in,
  input  wire logic                 tx_valid_in,
  output logic                      tx_ready_out,
  input  wire logic                 irq_request_in,
  input  wire logic                 irq_clear_in,
  output logic                      host_irq_n_out,
  output logic                      regs_defined_out,
  output logic                      register_valid_flag_out,
  output logic                      cmd_ready_out,
  output logic                      comm_ready_out,
  output logic [CAP_WIDTH-1:0]      capability_out
);

  // The readiness deadline depends on the self-test option.
  localparam int READY_CYC = SELFTEST_OPT ? SELFTEST_CYC : TIMEOUT_CYC;
  localparam int MAX_CYC   = (READY_CYC > COMM_CYC) ? READY_CYC : COMM_CYC;
  localparam int CNT_W     = $clog2(MAX_CYC + 1) + 1;
  localparam logic [CNT_W-1:0] COMM_LIM    = CNT_W'(COMM_CYC);
  localparam logic [CNT_W-1:0] DEFINED_LIM = CNT_W'(DEFINED_CYC);
  localparam logic [CNT_W-1:0] READY_LIM   = CNT_W'(READY_CYC);
  localparam logic [CNT_W-1:0] MAX_LIM     = CNT_W'(MAX_CYC);

  // Core-domain state.
  typedef struct packed {
    logic [CNT_W-1:0]     cnt;
    logic                 defined;
    logic                 reg_valid;
    logic                 comm_ready;
    logic [6:0]           addr;
    logic                 rxr_m;
    logic                 rxr_s;
    logic                 rx_ack;
    logic [7:0]           rx_data;
    logic                 rx_first;
    logic                 rx_valid;
    logic                 txr_m;
    logic                 txr_s;
    logic                 tx_ack;
    logic                 tx_ready;
    logic [7:0]           tx_hold;
    logic                 irq_pend;
    logic                 irq_n;
    logic [CAP_WIDTH-1:0] cap;
  } stl_core_type;

  // Link-domain state.
  typedef struct packed {
    logic          rst_m;
    logic          rst_s;
    logic          scl_m;
    logic          scl_s;
    logic          scl_p;
    logic          sda_m;
    logic          sda_s;
    logic          sda_p;
    logic          rdy_m;
    logic          rdy_s;
    logic [6:0]    addr_m;
    logic [6:0]    addr_s;
    logic          rxa_m;
    logic          rxa_s;
    logic          txa_m;
    logic          txa_s;
    stl_state_type state;
    logic [3:0]    bitcnt;
    logic [7:0]    shift;
    logic          rw;
    logic          nack;
    logic          first;
    logic          rx_req;
    logic          tx_req;
    logic          scl_oe;
    logic          sda_oe;
    logic          pin_low;
  } stl_link_type;

  stl_core_type c_q;
  stl_core_type c_d;
  stl_link_type l_q;
  stl_link_type l_d;

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [CAP_WIDTH-1:0] cap_word;

  // Capability word assembled from the build options.
  always_comb begin
    cap_word                                 = '0;
    cap_word[CAP_LOC_LSB +: 2]               = LOCALITY_OPT;
    cap_word[CAP_SPEED]                      = HIGH_SPEED;
    cap_word[CAP_GUARD_LSB +: 4]             = GUARD_NEEDED;
    cap_word[CAP_GUARD_SR]                   = GUARD_SR_NEED;
  end

  // Core domain: readiness timer, address, byte handshakes and the host interrupt.
  always_comb begin
    c_d          = c_q;
    c_d.rx_valid = 1'b0;
    c_d.cap      = cap_word;
    // The timer saturates so the flags never fall back once set.
    if (c_q.cnt != MAX_LIM) begin
      c_d.cnt = c_q.cnt + CNT_W'(1);
    end
    if (c_q.cnt >= DEFINED_LIM) begin
      c_d.defined = 1'b1;
    end
    if (c_q.cnt >= READY_LIM) begin
      c_d.reg_valid = 1'b1;
    end
    if (c_q.cnt >= COMM_LIM) begin
      c_d.comm_ready = 1'b1;
    end
    // Address change takes effect at the next address compare, even one inside the current frame.
    if (addr_load_in) begin
      c_d.addr = dev_addr_in;
    end
    // Toggle handshakes from the link; the byte fields are stable while a request is open.
    c_d.rxr_m = l_q.rx_req;
    c_d.rxr_s = c_q.rxr_m;
    c_d.txr_m = l_q.tx_req;
    c_d.txr_s = c_q.txr_m;
    if (c_q.rxr_s != c_q.rx_ack) begin
      c_d.rx_data  = l_q.shift;
      c_d.rx_first = l_q.first;
      c_d.rx_valid = 1'b1;
      c_d.rx_ack   = c_q.rxr_s;
    end
    if ((c_q.txr_s != c_q.tx_ack) && !c_q.tx_ready) begin
      c_d.tx_ready = 1'b1;
    end
    if (c_q.tx_ready && tx_valid_in) begin
      c_d.tx_hold  = tx_data_in;
      c_d.tx_ready = 1'b0;
      c_d.tx_ack   = ~c_q.tx_ack;
    end
    // A new event in the cycle of a clear keeps the interrupt pending.
    c_d.irq_pend = (c_q.irq_pend & ~irq_clear_in) | irq_request_in;
    c_d.irq_n    = ~c_d.irq_pend;
    if (!resetn_in) begin
      c_d       = '0;
      c_d.addr  = DEFAULT_ADDR;
      c_d.irq_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    c_q <= c_d;
  end

  // Bus conditions seen on the synchronised pins.
  assign scl_rise  = l_q.scl_s & ~l_q.scl_p;
  assign scl_fall  = ~l_q.scl_s & l_q.scl_p;
  assign bus_start = l_q.scl_s & l_q.scl_p & l_q.sda_p & ~l_q.sda_s;
  assign bus_stop  = l_q.scl_s & l_q.scl_p & ~l_q.sda_p & l_q.sda_s;

  // Link domain: bit-level target engine oversampling SCL and SDA.
  always_comb begin
    l_d        = l_q;
    l_d.scl_m  = scl_in;
    l_d.scl_s  = l_q.scl_m;
    l_d.scl_p  = l_q.scl_s;
    l_d.sda_m  = sda_in;
    l_d.sda_s  = l_q.sda_m;
    l_d.sda_p  = l_q.sda_s;
    l_d.rdy_m  = c_q.comm_ready;
    l_d.rdy_s  = l_q.rdy_m;
    l_d.addr_m = c_q.addr;
    l_d.addr_s = l_q.addr_m;
    l_d.rxa_m  = c_q.rx_ack;
    l_d.rxa_s  = l_q.rxa_m;
    l_d.txa_m  = c_q.tx_ack;
    l_d.txa_s  = l_q.txa_m;
    l_d.pin_low = 1'b0;
    if (bus_stop) begin
      l_d.state  = ST_IDLE;
      l_d.scl_oe = 1'b0;
      l_d.sda_oe = 1'b0;
    end else if (bus_start) begin
      // A repeated start lands here too, so read after write needs no stop.
      l_d.state  = ST_ADDR;
      l_d.bitcnt = '0;
      l_d.first  = 1'b1;
      l_d.scl_oe = 1'b0;
      l_d.sda_oe = 1'b0;
    end else begin
      case (l_q.state)
        ST_ADDR, ST_WR_BYTE: begin
          if (scl_rise) begin
            l_d.shift  = {l_q.shift[6:0], l_q.sda_s};
            l_d.bitcnt = l_q.bitcnt + 4'h1;
          end else if (scl_fall && (l_q.bitcnt == BYTE_BITS)) begin
            l_d.bitcnt = '0;
            if (l_q.state == ST_ADDR) begin
              // Foreign addresses, or any before the link is up, leave SDA released.
              if ((l_q.shift[7:1] == l_q.addr_s) && l_q.rdy_s) begin
                l_d.rw     = l_q.shift[0];
                l_d.sda_oe = 1'b1;
                l_d.state  = ST_ADDR_ACK;
              end else begin
                l_d.state = ST_IDLE;
              end
            end else begin
              // Hold SCL low until the core has taken the byte.
              l_d.scl_oe = 1'b1;
              l_d.rx_req = ~l_q.rx_req;
              l_d.state  = ST_WR_HOLD;
            end
          end
        end
        ST_WR_HOLD: begin
          if (l_q.rxa_s == l_q.rx_req) begin
            l_d.sda_oe = 1'b1;
            l_d.first  = 1'b0;
            l_d.state  = ST_WR_ACK;
          end
        end
        ST_WR_ACK: begin
          // SDA is set up a cycle before SCL is let go.
          if (l_q.scl_oe) begin
            l_d.scl_oe = 1'b0;
          end else if (scl_fall) begin
            l_d.sda_oe = 1'b0;
            l_d.state  = ST_WR_BYTE;
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            l_d.sda_oe = 1'b0;
            if (l_q.rw) begin
              l_d.scl_oe = 1'b1;
              l_d.tx_req = ~l_q.tx_req;
              l_d.state  = ST_RD_FETCH;
            end else begin
              l_d.state = ST_WR_BYTE;
            end
          end
        end
        ST_RD_FETCH: begin
          if (l_q.txa_s == l_q.tx_req) begin
            l_d.shift  = c_q.tx_hold;
            l_d.sda_oe = ~c_q.tx_hold[7];
            l_d.bitcnt = 4'h1;
            l_d.state  = ST_RD_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (l_q.scl_oe) begin
            l_d.scl_oe = 1'b0;
          end else if (scl_fall) begin
            if (l_q.bitcnt == BYTE_BITS) begin
              l_d.sda_oe = 1'b0;
              l_d.bitcnt = '0;
              l_d.state  = ST_RD_ACK;
            end else begin
              l_d.shift  = {l_q.shift[6:0], 1'b0};
              l_d.sda_oe = ~l_q.shift[6];
              l_d.bitcnt = l_q.bitcnt + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            l_d.nack = l_q.sda_s;
          end else if (scl_fall) begin
            if (!l_q.nack) begin
              l_d.scl_oe = 1'b1;
              l_d.tx_req = ~l_q.tx_req;
              l_d.state  = ST_RD_FETCH;
            end else begin
              l_d.state = ST_IDLE;
            end
          end
        end
        default: begin
          l_d.state = ST_IDLE;
        end
      endcase
    end
    // Reset follows the core reset through its own two-stage synchroniser.
    if (!l_q.rst_s) begin
      l_d = '0;
      // Pin history restarts at the idle-high level, so no false edge follows reset.
      l_d.scl_m = 1'b1;
      l_d.scl_s = 1'b1;
      l_d.scl_p = 1'b1;
      l_d.sda_m = 1'b1;
      l_d.sda_s = 1'b1;
      l_d.sda_p = 1'b1;
    end
    l_d.rst_m = resetn_in;
    l_d.rst_s = l_q.rst_m;
  end

  always_ff @(posedge link_clk_in) begin
    l_q <= l_d;
  end

  // Outputs straight from the state registers.
  assign scl_out                 = l_q.pin_low;
  assign scl_oe_out              = l_q.scl_oe;
  assign sda_out                 = l_q.pin_low;
  assign sda_oe_out              = l_q.sda_oe;
  assign rx_data_out             = c_q.rx_data;
  assign rx_first_out            = c_q.rx_first;
  assign rx_valid_out            = c_q.rx_valid;
  assign tx_ready_out            = c_q.tx_ready;
  assign host_irq_n_out          = c_q.irq_n;
  assign regs_defined_out        = c_q.defined;
  assign register_valid_flag_out = c_q.reg_valid;
  assign cmd_ready_out           = c_q.reg_valid;
  assign comm_ready_out          = c_q.comm_ready;
  assign capability_out          = c_q.cap;

endmodule : stl_target

// [logic/stl_pkg.sv]
// Constants, timing counts and state encodings for the secure-module I2C target link.
// Assumes a 100 MHz reference clock; shared by the target module, the checker and the bench.
// What this block does
// - Access register read always returns defined value
// - Register levels defined within 500 us
// - Without self-test: valid and ready by deadline
// - With self-test: valid and ready within 50ms
// - Bus communication available within 30ms after reset
// - Operate correctly at Fast-mode, 400 kbit/s
// - Higher speed capability reported in capability word
// - Single 7-bit address, default 0x2E
// - Device address may be reconfigured
// - Accept repeated START for read after write
// - Slow transfers only by holding SCL low
// - Active-low host interrupt signals response available
// - Locality option reported in capability word
// - Guard-time needs reported per access order
package stl_pkg;

  // Reference clock rate and the documented readiness times.
  localparam int REF_CLK_MHZ       = 100;
  localparam int COMM_READY_MS     = 30;
  localparam int COMM_READY_CYC    = COMM_READY_MS * 1000 * REF_CLK_MHZ;
  localparam int REG_DEFINED_US    = 500;
  localparam int REG_DEFINED_CYC   = REG_DEFINED_US * REF_CLK_MHZ;
  localparam int SELFTEST_READY_MS = 50;
  localparam int SELFTEST_READY_CYC = SELFTEST_READY_MS * 1000 * REF_CLK_MHZ;
  // Deadline for parts without the self-test option; plain default.
  localparam int READY_TIMEOUT_MS  = 30;
  localparam int READY_TIMEOUT_CYC = READY_TIMEOUT_MS * 1000 * REF_CLK_MHZ;

  // Bus addressing.
  localparam logic [6:0] DEFAULT_ADDR = 7'h2e;
  localparam logic [3:0] BYTE_BITS    = 4'h8;

  // Capability word layout.
  localparam int CAP_WIDTH    = 8;
  localparam int CAP_LOC_LSB  = 0;
  localparam int CAP_SPEED    = 2;
  localparam int CAP_GUARD_LSB = 3;
  localparam int CAP_GUARD_SR = 7;

  // Locality options.
  localparam logic [1:0] LOC_ONLY_0 = 2'h0;
  localparam logic [1:0] LOC_0_TO_4 = 2'h1;
  localparam logic [1:0] LOC_ALL    = 2'h2;

  // Link state machine, Gray coded in the order the states are listed.
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_WR_BYTE  = 4'h2,
    ST_WR_HOLD  = 4'h6,
    ST_WR_ACK   = 4'h7,
    ST_RD_FETCH = 4'h5,
    ST_RD_BYTE  = 4'h4,
    ST_RD_ACK   = 4'hc
  } stl_state_type;

endpackage : stl_pkg

// [verification/stl_props.sv]
// Checker of readiness timing, capability word, interrupt and the transmit byte handshake of the link.
// Assumes a bind to stl_target; every check runs on the reference clock.
`timescale 1ns/1ps
module stl_props
  import stl_pkg::*;
#(
  parameter int         DEFINED_CYC   = 50,
  parameter int         SELFTEST_CYC  = 400,
  parameter int         TIMEOUT_CYC   = 300,
  parameter int         COMM_CYC      = 200,
  parameter bit         SELFTEST_OPT  = 1'b0,
  parameter logic [1:0] LOCALITY_OPT  = 2'h0,
  parameter bit         HIGH_SPEED    = 1'b0,
  parameter logic [3:0] GUARD_NEEDED  = 4'hf,
  parameter bit         GUARD_SR_NEED = 1'b1
) (
  input wire logic                 ref_clk_in,
  input wire logic                 resetn_in,
  input wire logic                 sda_oe_out,
  input wire logic                 tx_valid_in,
  input wire logic                 tx_ready_out,
  input wire logic                 irq_request_in,
  input wire logic                 irq_clear_in,
  input wire logic                 host_irq_n_out,
  input wire logic                 regs_defined_out,
  input wire logic                 register_valid_flag_out,
  input wire logic                 cmd_ready_out,
  input wire logic                 comm_ready_out,
  input wire logic [CAP_WIDTH-1:0] capability_out
);
  localparam int READY_CYC = SELFTEST_OPT ? SELFTEST_CYC : TIMEOUT_CYC;
  int cnt_q;

  // Cycles since reset release; it saturates so that a long run cannot wrap it.
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      cnt_q <= 0;
    end else if (cnt_q < 1000000) begin
      cnt_q <= cnt_q + 1;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  // A byte is taken, or an interrupt cleared, only by these input patterns.
  sequence s_take;
    tx_ready_out && tx_valid_in;
  endsequence
  sequence s_clear;
    irq_clear_in && !irq_request_in;
  endsequence

  property p_defined;
    (cnt_q < DEFINED_CYC |-> !regs_defined_out) and (cnt_q > DEFINED_CYC + 1 |-> regs_defined_out);
  endproperty
  a_defined: assert property (p_defined) else $error("register levels not defined in time");
  property p_ready;
    cnt_q > READY_CYC + 1 |-> register_valid_flag_out && cmd_ready_out;
  endproperty
  a_ready: assert property (p_ready) else $error("registers or commands not ready in time");
  property p_flag;
    register_valid_flag_out |-> regs_defined_out;
  endproperty
  a_flag: assert property (p_flag) else $error("valid flag set before levels defined");
  property p_comm;
    cnt_q > COMM_CYC + 1 |-> comm_ready_out;
  endproperty
  a_comm: assert property (p_comm) else $error("bus not usable in time");
  property p_quiet;
    !comm_ready_out |-> !sda_oe_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("data line driven before bus usable");
  property p_cap;
    $past(resetn_in) |-> capability_out == {GUARD_SR_NEED, GUARD_NEEDED, HIGH_SPEED, LOCALITY_OPT};
  endproperty
  a_cap: assert property (p_cap) else $error("capability word wrong");
  property p_irq_set;
    irq_request_in |=> !host_irq_n_out;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt not raised");
  property p_irq_clr;
    s_clear |=> host_irq_n_out;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt not cleared");
  property p_irq_hold;
    !host_irq_n_out && !irq_clear_in |=> !host_irq_n_out;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without clear");
  property p_take;
    s_take |=> !tx_ready_out;
  endproperty
  a_take: assert property (p_take) else $error("byte request not withdrawn");
endmodule : stl_props

// [verification/stl_master.sv]
// Behavioural I2C bus master at Fast-mode rate, open drain on both lines.
// Assumes the bench resolves SCL and SDA from every enable, with a pull-up to 1.
`timescale 1ns/1ps
module stl_master #(
  parameter int Q_CYC     = 63,
  parameter int GUARD_CYC = 25000
) (
  input  wire logic clk_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_oe_out = 1'b0,
  output logic      sda_oe_out = 1'b0
);
  // Four quarters of 63 cycles give about 397 kbit/s, just inside Fast mode.
  task automatic q();
    repeat (Q_CYC) @(posedge clk_in);
  endtask : q
  // One bit; the release of SCL waits, bounded, while the target stretches it.
  task automatic bit_cycle(input logic low, output logic s);
    int n;
    sda_oe_out <= low;
    q();
    q();
    scl_oe_out <= 1'b0;
    @(posedge clk_in);
    for (n = 0; n < 20000 && scl_in !== 1'b1; n++) @(posedge clk_in);
    q();
    s = sda_in;
    q();
    scl_oe_out <= 1'b1;
  endtask : bit_cycle
  task automatic start();
    if (scl_oe_out) repeat (GUARD_CYC) @(posedge clk_in);
    sda_oe_out <= 1'b0;
    q();
    scl_oe_out <= 1'b0;
    q();
    sda_oe_out <= 1'b1;
    q();
    scl_oe_out <= 1'b1;
  endtask : start
  // The idle gap after STOP keeps the default guard time of the target.
  task automatic stop();
    sda_oe_out <= 1'b1;
    q();
    scl_oe_out <= 1'b0;
    q();
    sda_oe_out <= 1'b0;
    repeat (GUARD_CYC) @(posedge clk_in);
  endtask : stop
  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(!b[i], s);
    bit_cycle(1'b0, s);
    ack = !s;
  endtask : wr
  task automatic rd(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(1'b0, b[i]);
    bit_cycle(!nack, s);
  endtask : rd
endmodule : stl_master

// [verification/secure_module_i2c_target_link_tb.sv]
// Self-checking bench of the target link with a Fast-mode master model on the wires.
// Assumes the package, target, checker and master model are compiled before it.
`timescale 1ns/1ps
module secure_module_i2c_target_link_tb;
  import stl_pkg::*;
  localparam logic [3:0] GN = 4'h5;
  logic       ref_clk_in = 1'b0;
  logic       link_clk_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic       ld = 1'b0;
  logic       tx_v = 1'b0;
  logic       irq_rq = 1'b0;
  logic       irq_cl = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] tx_d = 8'h00;
  logic       s_oe, d_oe, ms_oe, md_oe, rx_f, rx_v, tx_r, irq_n, rdef, rval, cmd_r, com_r, ack, rx_fl, tx_i;
  logic       s_o, d_o;
  logic [7:0] rx_d, cap, rx_l, b;
  logic [7:0] tx_tab [2] = '{8'hc3, 8'h7e};
  int         err_count, checks;
  // Open-drain wires with board pull-ups; the target pulls low only with a low output level.
  wire        scl = !((s_oe & !s_o) | ms_oe);
  wire        sda = !((d_oe & !d_o) | md_oe);

  always #5 ref_clk_in = ~ref_clk_in;
  // Link clock at 6 ns, offset so its edges drift against the core clock.
  initial begin
    #0.7;
    forever #3 link_clk_in = ~link_clk_in;
  end

  stl_target #(.COMM_CYC(200), .DEFINED_CYC(50), .SELFTEST_CYC(400), .TIMEOUT_CYC(300),
    .LOCALITY_OPT(LOC_0_TO_4), .GUARD_NEEDED(GN)) i_dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .link_clk_in(link_clk_in), .scl_in(scl), .scl_out(s_o), .scl_oe_out(s_oe), .sda_in(sda),
    .sda_out(d_o), .sda_oe_out(d_oe), .dev_addr_in(addr), .addr_load_in(ld), .rx_data_out(rx_d),
    .rx_first_out(rx_f), .rx_valid_out(rx_v), .tx_data_in(tx_d), .tx_valid_in(tx_v),
    .tx_ready_out(tx_r), .irq_request_in(irq_rq), .irq_clear_in(irq_cl), .host_irq_n_out(irq_n),
    .regs_defined_out(rdef), .register_valid_flag_out(rval), .cmd_ready_out(cmd_r),
    .comm_ready_out(com_r), .capability_out(cap));
  stl_master #(.GUARD_CYC(2000)) i_mst (.clk_in(ref_clk_in), .scl_in(scl), .sda_in(sda),
    .scl_oe_out(ms_oe), .sda_oe_out(md_oe));

  // Captures each received byte; answers each byte request from a small table.
  always @(posedge ref_clk_in) begin
    if (rx_v === 1'b1) begin
      rx_l <= rx_d;
      rx_fl <= rx_f;
    end
    tx_v <= (tx_r === 1'b1);
    if (tx_r === 1'b1 && tx_v) tx_i <= !tx_i;
    tx_d <= tx_tab[tx_i];
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : cyc
  // Flags stay clean through reset and rise around each shortened deadline.
  task automatic t_timing();
    cyc(10);
    chk(8'(irq_n), 8'h01);
    resetn_in <= 1'b1;
    cyc(48);
    chk(8'(rdef), 8'h00);
    chk(8'(rval), 8'h00);
    cyc(6);
    chk(8'(rdef), 8'h01);
    cyc(150);
    chk(8'(com_r), 8'h01);
    cyc(100);
    chk(8'(rval), 8'h01);
    chk(8'(cmd_r), 8'h01);
    chk(cap, {1'b1, GN, 1'b0, LOC_0_TO_4});
    $display("test timing done");
  endtask : t_timing
  task automatic t_write();
    i_mst.start();
    i_mst.wr(8'h5c, ack);
    chk(8'(ack), 8'h01);
    i_mst.wr(8'ha5, ack);
    chk({rx_l[7:1], ack}, 8'ha5);
    chk(8'(rx_fl), 8'h01);
    i_mst.wr(8'h3c, ack);
    chk(rx_l, 8'h3c);
    chk(8'(rx_fl), 8'h00);
    i_mst.wr(8'h01, ack);
    chk(rx_l, 8'h01);
    // The read request goes out only once the write frame has been answered.
    i_mst.start();
    i_mst.wr(8'h5d, ack);
    chk(8'(ack), 8'h01);
    i_mst.rd(1'b0, b);
    chk(b, 8'hc3);
    i_mst.rd(1'b1, b);
    chk(b, 8'h7e);
    i_mst.stop();
    $display("test write and read done");
  endtask : t_write
  // The default and a loaded address, each against a foreign one.
  task automatic t_addr();
    i_mst.start();
    i_mst.wr(8'h5e, ack);
    chk(8'(ack), 8'h00);
    i_mst.stop();
    addr <= 7'h13;
    ld <= 1'b1;
    cyc(1);
    ld <= 1'b0;
    cyc(2);
    i_mst.start();
    i_mst.wr(8'h26, ack);
    chk(8'(ack), 8'h01);
    i_mst.stop();
    i_mst.start();
    i_mst.wr(8'h5c, ack);
    chk(8'(ack), 8'h00);
    i_mst.stop();
    $display("test address done");
  endtask : t_addr
  task automatic t_irq();
    irq_rq <= 1'b1;
    cyc(1);
    irq_rq <= 1'b0;
    cyc(2);
    chk(8'(irq_n), 8'h00);
    irq_cl <= 1'b1;
    cyc(1);
    irq_cl <= 1'b0;
    cyc(2);
    chk(8'(irq_n), 8'h01);
    {irq_rq, irq_cl} <= 2'h3;
    cyc(1);
    {irq_rq, irq_cl} <= 2'h0;
    cyc(2);
    chk(8'(irq_n), 8'h00);
    $display("test interrupt done");
  endtask : t_irq
  // A second reset mid-run drops the flags and the interrupt and restores the default address.
  task automatic t_reset();
    resetn_in <= 1'b0;
    cyc(10);
    chk(8'(irq_n), 8'h01);
    chk(8'({rdef, rval, com_r}), 8'h00);
    resetn_in <= 1'b1;
    cyc(2);
    chk(cap, {1'b1, GN, 1'b0, LOC_0_TO_4});
    cyc(205);
    chk(8'(com_r), 8'h01);
    i_mst.start();
    i_mst.wr(8'h5c, ack);
    chk(8'(ack), 8'h01);
    i_mst.stop();
    $display("test reset done");
  endtask : t_reset
  task automatic final_report();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    tx_i = 1'b0;
    t_timing();
    t_write();
    t_addr();
    t_irq();
    t_reset();
    final_report();
  end
  // Expected run is about 0.4 ms; a hang is cut off at twice that.
  initial begin
    #800000;
    err_count++;
    final_report();
  end
endmodule : secure_module_i2c_target_link_tb

bind stl_target stl_props #(.DEFINED_CYC(DEFINED_CYC), .SELFTEST_CYC(SELFTEST_CYC), .TIMEOUT_CYC(TIMEOUT_CYC),
  .COMM_CYC(COMM_CYC), .SELFTEST_OPT(SELFTEST_OPT), .LOCALITY_OPT(LOCALITY_OPT), .HIGH_SPEED(HIGH_SPEED),
  .GUARD_NEEDED(GUARD_NEEDED), .GUARD_SR_NEED(GUARD_SR_NEED)) i_props (.ref_clk_in(ref_clk_in),
  .resetn_in(resetn_in), .sda_oe_out(sda_oe_out), .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
  .irq_request_in(irq_request_in), .irq_clear_in(irq_clear_in), .host_irq_n_out(host_irq_n_out),
  .regs_defined_out(regs_defined_out), .register_valid_flag_out(register_valid_flag_out),
  .cmd_ready_out(cmd_ready_out), .comm_ready_out(comm_ready_out), .capability_out(capability_out));
